/* logic/jtd_deframer.sv */
// Receive transport deframer with deterministic-latency support.
// Assumes descrambled, deskewed lane words arrive synchronous to clk_in,
// four octets per lane per core clock, first octet in the top byte.
//
// Functional notes
// - Frame layout per lane follows programmed octets per frame: 1, 2 or 4.
// - Lanes per link 1,2,4,8 single link; only 1,2,4 dual link.
// - Converters per link 1,2,4 single link; only 1,2 dual link.
// - One or two samples per converter per frame, placed per setting.
// - Split-sample flag set exactly when one octet per lane per frame.
// - Samples are 16 bits resolution in 16 total bits, no padding.
// - Single link supports the ten listed M, L, S, F mode combinations.
// - Dual link supports modes 4-7, 9, 10 with same per-link set.
// - Unpack descrambled frames into converter samples per link settings.
// - Core clock is octet rate over four; frames per core is 4/F.
// - Per-link read-only latency from local boundary to first data.
// - Latency read-back wraps at K over 4/F core clocks.
// - Link parameters are programmed as value minus one.
// - Receive buffer delay takes 0 to 10 core clocks.
`timescale 1ns/1ps
`default_nettype none
module jtd_deframer #(
    parameter int LANES = 8,
    parameter int CONVS = 4,
    parameter int SPC = 4,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [LANES*32-1:0] lane_data_in,
    input wire logic lane_valid_in,
    output logic lane_ready_out,
    input wire logic sysref_mf_in,
    input wire logic [1:0] first_data_in,
    output logic [CONVS*SPC*16-1:0] smp_data_out,
    output logic smp_valid_out,
    input wire logic smp_ready_in,
    output logic cfg_error_out,
    output logic released_out
);
    localparam int DW = CONVS * SPC * 16;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] link_ctrl_r, lanes_r, octets_r, frames_r, convs_r;
    logic [7:0] res_r, np_r, samples_r, split_r;
    logic [7:0] mfd_a_r, mfd_b_r, var_a_r, var_b_r, lat0_r, lat1_r;
    logic [7:0] rd_mux;
    wire wr_en = ce_in && reg_wr_in;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_ctrl_r <= jtd_pkg::RST_ZERO;
            lanes_r <= jtd_pkg::RST_LANES;
            octets_r <= jtd_pkg::RST_OCTETS;
            frames_r <= jtd_pkg::RST_FRAMES;
            convs_r <= jtd_pkg::RST_CONVS;
            res_r <= jtd_pkg::RST_RES;
            np_r <= jtd_pkg::RST_NP;
            samples_r <= jtd_pkg::RST_SAMPLES;
            split_r <= jtd_pkg::RST_SPLIT;
            mfd_a_r <= jtd_pkg::RST_ZERO;
            mfd_b_r <= jtd_pkg::RST_ZERO;
            var_a_r <= jtd_pkg::RST_ZERO;
            var_b_r <= jtd_pkg::RST_ZERO;
        end else if (wr_en) begin
            case (reg_addr_in)
                jtd_pkg::ADDR_LINK_CTRL: link_ctrl_r <= reg_wdata_in;
                jtd_pkg::ADDR_LANES: lanes_r <= reg_wdata_in;
                jtd_pkg::ADDR_OCTETS: octets_r <= reg_wdata_in;
                jtd_pkg::ADDR_FRAMES: frames_r <= reg_wdata_in;
                jtd_pkg::ADDR_CONVS: convs_r <= reg_wdata_in;
                jtd_pkg::ADDR_RES: res_r <= reg_wdata_in;
                jtd_pkg::ADDR_NP: np_r <= reg_wdata_in;
                jtd_pkg::ADDR_SAMPLES: samples_r <= reg_wdata_in;
                jtd_pkg::ADDR_SPLIT: split_r <= reg_wdata_in;
                jtd_pkg::ADDR_MFD_A: mfd_a_r <= reg_wdata_in;
                jtd_pkg::ADDR_MFD_B: mfd_b_r <= reg_wdata_in;
                jtd_pkg::ADDR_VAR_A: var_a_r <= reg_wdata_in;
                jtd_pkg::ADDR_VAR_B: var_b_r <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (reg_addr_in)
            jtd_pkg::ADDR_LINK_CTRL: rd_mux = link_ctrl_r;
            jtd_pkg::ADDR_LAT0: rd_mux = lat0_r;
            jtd_pkg::ADDR_LAT1: rd_mux = lat1_r;
            jtd_pkg::ADDR_MFD_A: rd_mux = mfd_a_r;
            jtd_pkg::ADDR_MFD_B: rd_mux = mfd_b_r;
            jtd_pkg::ADDR_VAR_A: rd_mux = var_a_r;
            jtd_pkg::ADDR_VAR_B: rd_mux = var_b_r;
            jtd_pkg::ADDR_LANES: rd_mux = lanes_r;
            jtd_pkg::ADDR_OCTETS: rd_mux = octets_r;
            jtd_pkg::ADDR_FRAMES: rd_mux = frames_r;
            jtd_pkg::ADDR_CONVS: rd_mux = convs_r;
            jtd_pkg::ADDR_RES: rd_mux = res_r;
            jtd_pkg::ADDR_NP: rd_mux = np_r;
            jtd_pkg::ADDR_SAMPLES: rd_mux = samples_r;
            jtd_pkg::ADDR_SPLIT: rd_mux = split_r;
            default: rd_mux = jtd_pkg::RST_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Decoded link settings
    // ------------------------------------------------------------
    wire dual = link_ctrl_r[jtd_pkg::TWO_LINK_BIT];
    wire [4:0] l_m1 = lanes_r[4:0];
    wire [4:0] k_m1 = frames_r[4:0];
    wire [7:0] l_val = {3'b000, l_m1} + jtd_pkg::ENC_BIAS;
    wire [7:0] f_val = octets_r + jtd_pkg::ENC_BIAS;
    wire [7:0] m_val = convs_r + jtd_pkg::ENC_BIAS;
    wire [7:0] s_val = {3'b000, samples_r[4:0]} + jtd_pkg::ENC_BIAS;
    wire f_one = octets_r == jtd_pkg::RST_ZERO;
    wire tab_ok = jtd_pkg::cfg_legal(m_val[3:0], l_val[3:0], s_val[3:0],
        f_val[3:0], dual) && l_val[7:4] == 4'h0 && m_val[7:4] == 4'h0
        && f_val[7:4] == 4'h0;
    wire k_ok = f_one ? (k_m1 == jtd_pkg::K32_M1)
        : (k_m1 == jtd_pkg::K32_M1 || k_m1 == jtd_pkg::K16_M1);
    wire res_ok = res_r[4:0] == jtd_pkg::RES_M1
        && np_r[4:0] == jtd_pkg::RES_M1;
    wire split_ok = split_r[jtd_pkg::SPLIT_BIT] == f_one;
    wire cfg_bad = !(tab_ok && k_ok && res_ok && split_ok);
    wire [1:0] f_sh = octets_r[1] ? 2'd2 : {1'b0, octets_r[0]};
    wire [1:0] l_sh = l_m1[2] ? 2'd3 : l_m1[1] ? 2'd2 : {1'b0, l_m1[0]};
    wire [1:0] m_sh = convs_r[1] ? 2'd2 : {1'b0, convs_r[0]};
    wire s_sh = samples_r[0];
    wire [2:0] spc_sh = 3'({1'b0, l_sh} + 3'd1 - {1'b0, m_sh});
    // Core clocks per multiframe is K over frames-per-core (4/F)
    wire [1:0] fpc_sh = jtd_pkg::OCT_PER_CORE_SH - f_sh;
    wire [5:0] cpmf = 6'(({1'b0, k_m1} + 6'd1) >> fpc_sh);
    wire [5:0] cpmf_last = cpmf - 6'd1;

    // ------------------------------------------------------------
    // Deframing: octet array, then per converter/sample selection
    // ------------------------------------------------------------
    logic [7:0] oct [LANES*4];
    logic [DW-1:0] defr_data;

    function automatic logic [4:0] oct_idx(input logic [3:0] o,
            input logic [1:0] fr, input logic [1:0] fsh,
            input logic [2:0] off);
        logic [2:0] lane;
        logic [1:0] pos;
        lane = 3'(o >> fsh) + off;
        pos = 2'(fr << fsh) | (o[1:0] & 2'((3'd1 << fsh) - 3'd1));
        return {lane, pos};
    endfunction : oct_idx

    for (genvar g = 0; g < LANES*4; g++) begin : g_oct
        assign oct[g] = lane_data_in[(g/4)*32 + (3-g%4)*8 +: 8];
    end

    for (genvar c = 0; c < CONVS; c++) begin : g_conv
        for (genvar t = 0; t < SPC; t++) begin : g_smp
            // Link 1 reuses link 0's layout on the upper lanes
            wire hi = dual && c >= 2;
            wire [1:0] cl = hi ? 2'(c - 2) : 2'(c);
            wire [2:0] off = hi ? 3'd4 : 3'd0;
            wire [1:0] fr = 2'(t >> s_sh);
            wire [3:0] o = 4'((({2'b00, cl} << s_sh) + 4'(t & s_sh)) << 1);
            wire [4:0] i0 = oct_idx(o, fr, f_sh, off);
            wire [4:0] i1 = oct_idx(o + 4'd1, fr, f_sh, off);
            wire use_c = {1'b0, cl} < m_val[2:0];
            wire use_t = t < (1 << spc_sh);
            assign defr_data[(c*SPC + t)*16 +: 16] = (use_c && use_t)
                ? {oct[i0], oct[i1]} : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Local multiframe timing and latency read-back
    // ------------------------------------------------------------
    logic [5:0] lmfc_cnt_r;
    logic [5:0] lat_cnt_r [2];
    logic [5:0] dly_core [2];
    logic [1:0] bnd;
    logic [7:0] mfd [2];
    assign mfd[0] = mfd_a_r;
    assign mfd[1] = mfd_b_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            lmfc_cnt_r <= '0;
        else if (ce_in)
            lmfc_cnt_r <= (sysref_mf_in || lmfc_cnt_r >= cpmf_last)
                ? 6'd0 : lmfc_cnt_r + 6'd1;
    end

    for (genvar k = 0; k < 2; k++) begin : g_link
        // Delay is in frame clocks; convert and fold into one multiframe
        assign dly_core[k] = 6'(mfd[k] >> fpc_sh) & cpmf_last;
        assign bnd[k] = lmfc_cnt_r == dly_core[k];
        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in)
                lat_cnt_r[k] <= '0;
            else if (ce_in)
                lat_cnt_r[k] <= (bnd[k] || lat_cnt_r[k] >= cpmf_last)
                    ? 6'd0 : lat_cnt_r[k] + 6'd1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lat0_r <= jtd_pkg::RST_ZERO;
            lat1_r <= jtd_pkg::RST_ZERO;
        end else if (ce_in) begin
            if (first_data_in[0])
                lat0_r <= {2'b00, lat_cnt_r[0]};
            if (first_data_in[1])
                lat1_r <= {2'b00, lat_cnt_r[1]};
        end
    end

    // ------------------------------------------------------------
    // Receive buffer delay: hold output until boundary + variation
    // ------------------------------------------------------------
    logic seen_r, arm_r, release_r;
    logic [7:0] hold_cnt_r;
    // Settings past the buffer limit are clamped rather than refused
    wire [7:0] var_lim = (var_a_r > jtd_pkg::HOLD_MAX)
        ? jtd_pkg::HOLD_MAX : var_a_r;
    wire hold_hit = arm_r && hold_cnt_r == var_lim;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            seen_r <= 1'b0;
            arm_r <= 1'b0;
            release_r <= 1'b0;
            hold_cnt_r <= '0;
        end else if (ce_in) begin
            seen_r <= seen_r || first_data_in[0];
            arm_r <= arm_r || (seen_r && bnd[0]);
            if (arm_r && !release_r && !hold_hit)
                hold_cnt_r <= hold_cnt_r + 8'd1;
            release_r <= release_r || hold_hit;
        end
    end

    // ------------------------------------------------------------
    // FIFO and registered output stage
    // ------------------------------------------------------------
    logic fifo_vld;
    logic [DW-1:0] fifo_data;
    logic smp_valid_r, cfg_err_r;
    logic [DW-1:0] smp_data_r;
    logic [7:0] rdata_r;
    wire take = release_r && fifo_vld && (!smp_valid_r || smp_ready_in);

    jtd_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .in_valid_in(lane_valid_in && !cfg_err_r),
        .in_ready_out(lane_ready_out),
        .in_data_in(defr_data),
        .out_valid_out(fifo_vld),
        .out_ready_in(take),
        .out_data_out(fifo_data)
    );

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            smp_valid_r <= 1'b0;
            smp_data_r <= '0;
            cfg_err_r <= 1'b0;
            rdata_r <= jtd_pkg::RST_ZERO;
        end else if (ce_in) begin
            if (take)
                smp_data_r <= fifo_data;
            if (take || smp_ready_in)
                smp_valid_r <= take;
            cfg_err_r <= cfg_bad;
            if (reg_rd_in)
                rdata_r <= rd_mux;
        end
    end

    assign smp_data_out = smp_data_r;
    assign smp_valid_out = smp_valid_r;
    assign cfg_error_out = cfg_err_r;
    assign released_out = release_r;
    assign reg_rdata_out = rdata_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_k_one_octet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && f_one && k_m1 != jtd_pkg::K32_M1 |=> cfg_error_out)
        else $error("K other than 32 with F of one not flagged");
    a_dual_lanes: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && dual && l_m1 == 5'd7 |=> cfg_error_out)
        else $error("eight lanes accepted in dual link");
    a_dual_convs: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && dual && convs_r == 8'h03 |=> cfg_error_out)
        else $error("four converters accepted in dual link");
    a_split_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && split_r[jtd_pkg::SPLIT_BIT] != f_one
        |=> cfg_error_out)
        else $error("split-sample flag mismatch not flagged");
    a_res_fixed: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && res_r[4:0] != jtd_pkg::RES_M1 |=> cfg_error_out)
        else $error("resolution other than 16 not flagged");
    a_mode_ok: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && !dual && l_m1 == 5'd0 && convs_r == 8'h01 && f_val == 8'd4
        && s_val == 8'd1 && k_m1 == jtd_pkg::K16_M1 && res_ok
        && !split_r[jtd_pkg::SPLIT_BIT] |=> !cfg_error_out)
        else $error("legal mode 7 flagged as error");
    a_lat_wrap: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        lat_cnt_r[0] <= cpmf_last || $changed(frames_r)
        || $changed(octets_r))
        else $error("latency counter beyond multiframe");
    a_lat_capture: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ce_in && first_data_in[1] |=> lat1_r == {2'b00, $past(lat_cnt_r[1])})
        else $error("link 1 latency not captured");
    a_hold_limit: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(release_r) |-> $past(hold_cnt_r) <= jtd_pkg::HOLD_MAX)
        else $error("buffer delay beyond ten core clocks");
    a_out_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        smp_valid_out && !smp_ready_in |=> smp_valid_out
        && $stable(smp_data_out))
        else $error("sample group dropped under back-pressure");

    c_dual_data: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        dual && !cfg_error_out && smp_valid_out && smp_ready_in);
    c_release: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(release_r) && var_a_r != 8'h00);
    c_lat_read: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        first_data_in[0] ##1 reg_rd_in && reg_addr_in == jtd_pkg::ADDR_LAT0);
    c_fifo_full: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        lane_valid_in && !lane_ready_out);
endmodule : jtd_deframer
`default_nettype wire

/* logic/jtd_fifo.sv */
// Sample FIFO between deframer and the released output stage.
// Assumes DEPTH is a power of two; status outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module jtd_fifo #(
    parameter int WIDTH = 256,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic rdy_r;
    logic vld_r;
    wire push = ce_in && in_valid_in && rdy_r;
    wire pop = ce_in && out_ready_in && vld_r;

    assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    assign in_ready_out = rdy_r;
    assign out_valid_out = vld_r;
    assign out_data_out = mem[rd_ptr_r];

    // Storage has no reset: contents are only read while valid
    always_ff @(posedge clk_in) begin
        if (push)
            mem[wr_ptr_r] <= in_data_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
            vld_r <= 1'b0;
        end else if (ce_in) begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            cnt_r <= cnt_nxt;
            rdy_r <= cnt_nxt != FULL_CNT;
            vld_r <= cnt_nxt != '0;
        end
    end

    a_fifo_bound: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        cnt_r <= FULL_CNT) else $error("fifo count above depth");
endmodule : jtd_fifo
`default_nettype wire

/* logic/jtd_pkg.sv */
// Constants used by the transport deframer; its sample FIFO uses none.
// Assumes register offsets are the device's byte-wide map addresses.
`default_nettype none
package jtd_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_LINK_CTRL = 12'h0300;
    localparam logic [11:0] ADDR_LAT0 = 12'h0302;
    localparam logic [11:0] ADDR_LAT1 = 12'h0303;
    localparam logic [11:0] ADDR_MFD_A = 12'h0304;
    localparam logic [11:0] ADDR_MFD_B = 12'h0305;
    localparam logic [11:0] ADDR_VAR_A = 12'h0306;
    localparam logic [11:0] ADDR_VAR_B = 12'h0307;
    localparam logic [11:0] ADDR_LANES = 12'h0453;
    localparam logic [11:0] ADDR_OCTETS = 12'h0454;
    localparam logic [11:0] ADDR_FRAMES = 12'h0455;
    localparam logic [11:0] ADDR_CONVS = 12'h0456;
    localparam logic [11:0] ADDR_RES = 12'h0457;
    localparam logic [11:0] ADDR_NP = 12'h0458;
    localparam logic [11:0] ADDR_SAMPLES = 12'h0459;
    localparam logic [11:0] ADDR_SPLIT = 12'h045A;
    // ------------------------------------------------------------
    // Field positions and reset values (mode 0 layout)
    // ------------------------------------------------------------
    localparam int TWO_LINK_BIT = 3;
    localparam int SPLIT_BIT = 7;
    localparam logic [7:0] RST_LANES = 8'h07;
    localparam logic [7:0] RST_OCTETS = 8'h00;
    localparam logic [7:0] RST_FRAMES = 8'h1F;
    localparam logic [7:0] RST_CONVS = 8'h03;
    localparam logic [7:0] RST_RES = 8'h0F;
    localparam logic [7:0] RST_NP = 8'h0F;
    localparam logic [7:0] RST_SAMPLES = 8'h00;
    localparam logic [7:0] RST_SPLIT = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ------------------------------------------------------------
    // Link figures
    // ------------------------------------------------------------
    localparam logic [4:0] K32_M1 = 5'h1F;
    localparam logic [4:0] K16_M1 = 5'h0F;
    localparam logic [4:0] RES_M1 = 5'h0F;
    localparam logic [7:0] ENC_BIAS = 8'h01;
    localparam logic [1:0] OCT_PER_CORE_SH = 2'h2;
    localparam logic [7:0] HOLD_MAX = 8'h0A;
    localparam int NUM_MODES = 10;
    localparam int DUAL_FIRST = 4;
    // {M, L, S, F} per mode, in order 0..7, 9, 10
    localparam logic [15:0] MODE_TAB [NUM_MODES] = '{
        16'h4811, 16'h4822, 16'h4412, 16'h4214, 16'h2411,
        16'h2422, 16'h2212, 16'h2114, 16'h1211, 16'h1112};

    function automatic logic cfg_legal(input logic [3:0] m,
            input logic [3:0] l, input logic [3:0] s,
            input logic [3:0] f, input logic dual);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < NUM_MODES; i++) begin
            if (MODE_TAB[i] == {m, l, s, f} && (!dual || i >= DUAL_FIRST))
                ok = 1'b1;
        end
        return ok;
    endfunction : cfg_legal
endpackage : jtd_pkg
`default_nettype wire

/* sim/jesd_transport_deframer_latency_bench.sv */
// Bench: registers, config checks, latency, release, sample order.
// Assumes mode 0 after reset and FIFO depth 4.
`timescale 1ns/1ps
`default_nettype none
module jesd_transport_deframer_latency_bench;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [11:0] addr = 12'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic smp_ready = 1'b0;
    logic ce = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [255:0] lane_data, smp_data;
    logic lane_valid, lane_ready, sysref, smp_valid, cfg_err, released;
    logic [1:0] first_data;
    int err_total = 0;
    int checked = 0;
    int n = 0;
    int w;
    always #50 clk_in = ~clk_in;
    jtd_deframer #(.FIFO_DEPTH(4)) uut (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .ce_in(ce), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .lane_data_in(lane_data),
        .lane_valid_in(lane_valid), .lane_ready_out(lane_ready),
        .sysref_mf_in(sysref), .first_data_in(first_data),
        .smp_data_out(smp_data), .smp_valid_out(smp_valid),
        .smp_ready_in(smp_ready), .cfg_error_out(cfg_err),
        .released_out(released));
    jtd_tx_model u_tx (.clk_in(clk_in), .lane_ready_in(lane_ready),
        .lane_data_out(lane_data), .lane_valid_out(lane_valid),
        .sysref_out(sysref), .first_data_out(first_data));
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in) #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk_in) #1 wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_in) #1 addr = a;
        rd = 1'b1;
        @(posedge clk_in) #1 rd = 1'b0;
        chk({248'h0, rdata}, {248'h0, e});
    endtask : rd_chk
    task automatic cfg_chk(input logic [11:0] a, input logic [7:0] d,
            input logic e);
        wr_reg(a, d);
        repeat (2) @(posedge clk_in);
        #1 chk({255'h0, cfg_err}, {255'h0, e});
    endtask : cfg_chk
    function automatic logic [255:0] exp_smp(input logic [255:0] x);
        for (int c = 0; c < 4; c++)
            for (int t = 0; t < 4; t++)
                exp_smp[(c*4+t)*16 +: 16] =
                    {x[(8*c+3-t)*8 +: 8], x[(8*c+7-t)*8 +: 8]};
    endfunction : exp_smp
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge clk_in);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        rd_chk(12'h0304, 8'h00);
        wr_reg(12'h0304, 8'h1A);
        rd_chk(12'h0304, 8'h1A);
        wr_reg(12'h0302, 8'h55);
        rd_chk(12'h0302, 8'h00);
        rd_chk(12'h03FF, 8'h00);
        // Clock enable low: the write must not land
        ce = 1'b0;
        wr_reg(12'h0305, 8'h33);
        ce = 1'b1;
        rd_chk(12'h0305, 8'h00);
        $display("test registers done");
        cfg_chk(12'h045A, 8'h00, 1'b1);
        cfg_chk(12'h045A, 8'h80, 1'b0);
        cfg_chk(12'h0300, 8'h08, 1'b1);
        cfg_chk(12'h0300, 8'h00, 1'b0);
        cfg_chk(12'h0455, 8'h0F, 1'b1);
        cfg_chk(12'h0455, 8'h1F, 1'b0);
        $display("test config done");
        wr_reg(12'h0304, 8'h00);
        wr_reg(12'h0305, 8'h00);
        wr_reg(12'h0306, 8'h0C);
        wr_reg(12'h0307, 8'h0C);
        u_tx.align(11);
        rd_chk(12'h0302, 8'h01);
        rd_chk(12'h0303, 8'h01);
        // Clamped hold of ten: release lands on the thirteenth edge
        repeat (12) @(posedge clk_in);
        #1 chk({255'h0, released}, 256'h0);
        @(posedge clk_in);
        #1 chk({255'h0, released}, 256'h1);
        $display("test latency done");
        while (lane_ready === 1'b1 && n < 40) begin
            u_tx.send(n);
            n++;
        end
        chk(256'(n), 256'h5);
        smp_ready = 1'b1;
        for (int i = 0; i < n; i++) begin
            w = 0;
            while (smp_valid !== 1'b1 && w < 20) begin
                @(posedge clk_in) #1 w++;
            end
            chk(smp_data, exp_smp(u_tx.pat(i)));
            @(posedge clk_in) #1;
        end
        $display("test samples done");
        wr_reg(12'h0456, 8'h01);
        wr_reg(12'h0453, 8'h00);
        wr_reg(12'h0454, 8'h03);
        wr_reg(12'h0455, 8'h0F);
        cfg_chk(12'h045A, 8'h00, 1'b0);
        $display("test mode seven done");
        tally_and_finish();
    end
endmodule : jesd_transport_deframer_latency_bench
`default_nettype wire

/* sim/jtd_tx_model.sv */
// Transmitter stand-in: lane words, multiframe and first-data pulses.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module jtd_tx_model (
    input wire logic clk_in,
    input wire logic lane_ready_in,
    output logic [255:0] lane_data_out,
    output logic lane_valid_out,
    output logic sysref_out,
    output logic [1:0] first_data_out
);
    initial begin
        lane_data_out = 256'h0;
        lane_valid_out = 1'b0;
        sysref_out = 1'b0;
        first_data_out = 2'h0;
    end
    function automatic logic [255:0] pat(input int k);
        for (int i = 0; i < 32; i++)
            pat[8*i +: 8] = 8'(k * 32 + i);
    endfunction : pat
    // First data lands gap clocks after the boundary edge
    task automatic align(input int gap);
        @(posedge clk_in) #1 sysref_out = 1'b1;
        @(posedge clk_in) #1 sysref_out = 1'b0;
        repeat (gap - 1) @(posedge clk_in);
        #1 first_data_out = 2'h3;
        @(posedge clk_in) #1 first_data_out = 2'h0;
    endtask : align
    // Idle lanes show the inverse so stale data never looks valid
    task automatic send(input int k);
        logic ok;
        @(posedge clk_in) #1 lane_valid_out = 1'b1;
        lane_data_out = pat(k);
        do begin
            ok = lane_ready_in;
            @(posedge clk_in);
        end while (!ok);
        #1 lane_valid_out = 1'b0;
        lane_data_out = ~lane_data_out;
    endtask : send
endmodule : jtd_tx_model
`default_nettype wire
